// *** hw/udc_defs.vh ***
/*
  Register map, field positions and reset values of the USB device-mode
  control register block. Included by the udc_ctrl design; definitions only.
*/
`ifndef UDC_DEFS_VH
`define UDC_DEFS_VH

`define UDC_CTRL_ADDR 12'h000
`define UDC_STAT_ADDR 12'h004
`define UDC_ADDR_W 12
`define UDC_REG_W 16
`define UDC_CTRL_RST 16'h0000
`define UDC_CTRL_WMASK 16'h002f
`define UDC_STAT_RST 16'h0000
`define UDC_CNT_STEP 16'h0001
`define UDC_RD_PAD 16'h0000
`define UDC_RDATA_RST 32'h0000_0000
`define UDC_BIT_EN 0
`define UDC_BIT_PPRST 1
`define UDC_BIT_RESUME 2
`define UDC_BIT_HOST 3
`define UDC_BIT_PACKET_TRANSFER_DISABLE 5
`define UDC_BIT_SE0 6
`define UDC_STAT_PPCNT 15
`define UDC_SE0_STAGES 2

`endif

// *** hw/udc_flag.v ***
/*
  Sticky flag set by hardware and cleared by software; set wins over clear.
  Assumes set and clear are single-cycle pulses in the pclk domain.
*/
`timescale 1ns/1ps
`default_nettype none

module udc_flag (
  input wire pclk, // Clock
  input wire presetn, // Async reset, active low
  input wire set, // Hardware set pulse
  input wire clr, // Software clear
  input wire wr_en, // Software write strobe
  input wire wr_val, // Software write value
  output reg q_r // Flag state
);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r <= 1'b0;
    end else if (set) begin
      q_r <= 1'b1;
    end else if (clr) begin
      q_r <= 1'b0;
    end else if (wr_en) begin
      q_r <= wr_val;
    end
  end

endmodule // udc_flag

`default_nettype wire

// *** hw/udc_ctrl.v ***
/*
  USB device-mode control and status register block with APB slave.
  Holds the control word at one offset and a wrapping count of
  ping-pong pointer resets at the next; the enables leave as
  registered levels, the pointer reset as a one-cycle pulse.
  Unmapped offsets read zero and answer with pslverr high.
  Assumes the engine reports SETUP tokens as one-cycle pulses, the
  bus single-ended-zero level is synchronous to pclk, and the APB
  master keeps to its setup and access phases; pready stays high.
*/
// Decided for this implementation: the APB slave port and the placing of the registers.
// Overview of operation
// - Live single-ended-zero flag reads one while SE0 is on the bus.
// - Packet-transfer-disable high suspends all token and packet processing.
// - A received SETUP token sets packet-transfer-disable automatically.
// - Host-capability enable turns on host mode and D+/D- pull-downs.
// - Resume signalling is driven while the resume bit is one.
// - Writing one to ping-pong reset returns all pointers to even bank.
// - Module enable high enables module, attaches, turns on D+ pull-up.
// - Module enable low disables module and appears detached.
// - Unimplemented control bits read as zero.
`timescale 1ns/1ps
`default_nettype none
`include "udc_defs.vh"

module udc_ctrl #(
  parameter ADDR_W = `UDC_ADDR_W // APB address width
) (
  input wire pclk, // Clock, 100 MHz
  input wire presetn, // Async reset, active low
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire pwrite, // APB write
  input wire [ADDR_W-1:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output wire pready, // APB ready
  output reg [31:0] prdata, // APB read data
  output wire pslverr, // APB error
  input wire bus_se0, // Line state: single-ended zero seen
  input wire setup_token, // Engine pulse: SETUP token received
  output reg module_enable, // Module and circuitry enabled
  output reg dp_pullup_en, // D+ pull-up on (attached)
  output reg host_capability_enable, // Host mode enabled
  output reg host_pulldown_en, // D+ and D- pull-downs on
  output reg resume_drive, // Drive resume signalling
  output reg packet_transfer_disable, // Engine processing suspended
  output reg pingpong_pointer_reset // Pulse: pointers to even bank
);

  reg [1:0] se0_sync_r;
  reg module_enable_r;
  reg module_enable_nxt;
  reg host_en_r;
  reg host_en_nxt;
  reg resume_r;
  reg resume_nxt;
  reg [`UDC_REG_W-1:0] pp_count_r;
  reg [`UDC_REG_W-1:0] pp_count_nxt;
  reg [31:0] prdata_nxt;
  reg [`UDC_REG_W-1:0] ctrl_rd;

  wire packet_transfer_disable_q;
  wire wr_fire;
  wire rd_setup;
  wire ctrl_hit;
  wire stat_hit;
  wire ctrl_wr;
  wire packet_transfer_disable_clr;
  wire pprst_req;

  // Zero wait states: every access phase completes at once
  assign pready = 1'b1;
  assign wr_fire = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign ctrl_hit = (paddr == `UDC_CTRL_ADDR);
  assign stat_hit = (paddr == `UDC_STAT_ADDR);
  assign ctrl_wr = wr_fire & ctrl_hit;
  assign packet_transfer_disable_clr = ctrl_wr & ~pwdata[`UDC_BIT_PACKET_TRANSFER_DISABLE];
  assign pprst_req = ctrl_wr & pwdata[`UDC_BIT_PPRST];
  // Unmapped offsets answer with an error and change nothing
  assign pslverr = psel & penable & ~(ctrl_hit | stat_hit);

  // Live SE0 sampled into the register view
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      se0_sync_r <= 2'b00;
    end else begin
      se0_sync_r <= {se0_sync_r[0], bus_se0};
    end
  end

  // Next value of the writable control bits
  always @* begin
    module_enable_nxt = module_enable_r;
    host_en_nxt = host_en_r;
    resume_nxt = resume_r;
    if (ctrl_wr) begin
      module_enable_nxt = pwdata[`UDC_BIT_EN];
      host_en_nxt = pwdata[`UDC_BIT_HOST];
      resume_nxt = pwdata[`UDC_BIT_RESUME];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      module_enable_r <= 1'b0;
      host_en_r <= 1'b0;
      resume_r <= 1'b0;
    end else begin
      module_enable_r <= module_enable_nxt;
      host_en_r <= host_en_nxt;
      resume_r <= resume_nxt;
    end
  end

  // SETUP token beats a same-cycle software clear
  udc_flag i_udc_flag (
    .pclk(pclk),
    .presetn(presetn),
    .set(setup_token),
    .clr(packet_transfer_disable_clr),
    .wr_en(ctrl_wr),
    .wr_val(pwdata[`UDC_BIT_PACKET_TRANSFER_DISABLE]),
    .q_r(packet_transfer_disable_q)
  );

  // Count of pointer resets, for software visibility
  always @* begin
    pp_count_nxt = pp_count_r;
    if (pprst_req) begin
      pp_count_nxt = pp_count_r + `UDC_CNT_STEP;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pp_count_r <= `UDC_STAT_RST;
    end else begin
      pp_count_r <= pp_count_nxt;
    end
  end

  // Attach: module enable brings the D+ pull-up with it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      module_enable <= 1'b0;
      dp_pullup_en <= 1'b0;
    end else begin
      module_enable <= module_enable_r;
      dp_pullup_en <= module_enable_r;
    end
  end

  // Host mode brings both pull-downs with it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_capability_enable <= 1'b0;
      host_pulldown_en <= 1'b0;
    end else begin
      host_capability_enable <= host_en_r;
      host_pulldown_en <= host_en_r;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resume_drive <= 1'b0;
    end else begin
      resume_drive <= resume_r;
    end
  end

  // Engine halt follows the flag, whoever set it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      packet_transfer_disable <= 1'b0;
    end else begin
      packet_transfer_disable <= packet_transfer_disable_q;
    end
  end

  // One pulse per write of one; a write of zero leaves pointers alone
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pingpong_pointer_reset <= 1'b0;
    end else begin
      pingpong_pointer_reset <= pprst_req;
    end
  end

  // Reserved bits and reset bit read zero; SE0 is read-only
  always @* begin
    ctrl_rd = `UDC_CTRL_RST;
    ctrl_rd[`UDC_BIT_EN] = module_enable_r;
    ctrl_rd[`UDC_BIT_RESUME] = resume_r;
    ctrl_rd[`UDC_BIT_HOST] = host_en_r;
    ctrl_rd[`UDC_BIT_PACKET_TRANSFER_DISABLE] = packet_transfer_disable_q;
    ctrl_rd[`UDC_BIT_SE0] = se0_sync_r[1];
  end

  // Read data is latched in the setup cycle and stands in the access phase
  always @* begin
    prdata_nxt = prdata;
    if (rd_setup) begin
      if (ctrl_hit) begin
        prdata_nxt = {`UDC_RD_PAD, ctrl_rd};
      end else if (stat_hit) begin
        prdata_nxt = {`UDC_RD_PAD, pp_count_r};
      end else begin
        prdata_nxt = `UDC_RDATA_RST;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `UDC_RDATA_RST;
    end else begin
      prdata <= prdata_nxt;
    end
  end

endmodule // udc_ctrl

`default_nettype wire

// *** tb/udc_props.sv ***
/* Port checker for udc_ctrl; assumes the 12-bit default address width. */
`timescale 1ns/1ps
`default_nettype none
module udc_props (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic setup_token, // SETUP pulse
  input wire logic [11:0] paddr, // Address
  input wire logic [31:0] pwdata, // Write data
  input wire logic [31:0] prdata, // Read data
  input wire logic module_enable, // Module enabled
  input wire logic host_capability_enable, // Host mode
  input wire logic resume_drive, // Resume signalling
  input wire logic packet_transfer_disable, // Processing halted
  input wire logic pingpong_pointer_reset // Pointer reset pulse
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic w = psel & penable & pwrite & paddr == 12'h000;
  property p_en; w |-> ##2 module_enable == $past(pwdata[0], 2); endproperty
  a_en: assert property (p_en) else $error("en");
  property p_ho; w |-> ##2 host_capability_enable == $past(pwdata[3], 2); endproperty
  a_ho: assert property (p_ho) else $error("host");
  property p_rs; w |-> ##2 resume_drive == $past(pwdata[2], 2); endproperty
  a_rs: assert property (p_rs) else $error("resume");
  property p_pp; w && pwdata[1] |=> pingpong_pointer_reset; endproperty
  a_pp: assert property (p_pp) else $error("pp");
  property p_pz; !(w && pwdata[1]) |=> !pingpong_pointer_reset; endproperty
  a_pz: assert property (p_pz) else $error("pp idle");
  property p_su; setup_token |-> ##2 packet_transfer_disable; endproperty
  a_su: assert property (p_su) else $error("setup");
  property p_pk; w && !setup_token |-> ##2 packet_transfer_disable == $past(pwdata[5], 2); endproperty
  a_pk: assert property (p_pk) else $error("packet_transfer_disable");
  property p_rd; psel & !penable & !pwrite & paddr == 12'h000
    |=> (prdata & 32'hffff_ff92) == 32'h0000_0000; endproperty
  a_rd: assert property (p_rd) else $error("unused");
  c_w: cover property (w);
  c_su: cover property (setup_token);
  c_pp: cover property (pingpong_pointer_reset);
endmodule // udc_props
bind udc_ctrl udc_props i_udc_props (.*);
`default_nettype wire

// *** tb/udc_host.sv ***
/* Line-side stand-in: SETUP pulses and line state, timed on pclk. */
`timescale 1ns/1ps
`default_nettype none
module udc_host (
  input wire logic pclk, // Clock
  output logic bus_se0 = 0, // Line state
  output logic setup_token = 0 // SETUP pulse
);
  task tok;
    @(posedge pclk) setup_token <= 1;
    @(posedge pclk) setup_token <= 0;
  endtask
  task se0(input logic v);
    @(posedge pclk) bus_se0 <= v;
  endtask
endmodule // udc_host
`default_nettype wire

// *** tb/testbench.sv ***
/* APB bench for udc_ctrl; udc_host drives the line side. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0;
  wire logic pready, pslverr, bus_se0, setup_token;
  wire logic [31:0] prdata;
  wire logic [6:0] o;
  int error_cnt = 0, tests_run = 0;
  always #5 pclk = ~pclk;
  udc_host i_udc_host (.*);
  udc_ctrl i_udc_ctrl (.*, .module_enable(o[6]), .dp_pullup_en(o[5]),
    .host_capability_enable(o[4]), .host_pulldown_en(o[3]), .resume_drive(o[2]),
    .packet_transfer_disable(o[1]), .pingpong_pointer_reset(o[0]));
  task ck(string n, logic [31:0] s, e);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask
  // Reads pass the expected word as d
  task xf(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1);
    ck("slverr", pslverr, a != 12'h000 && a != 12'h004);
    if (!w) ck("reg", prdata, d);
    psel <= 0;
    penable <= 0;
  endtask
  task test_done;
    $display("%0d checks, %0d errors", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #5000;
    error_cnt++;
    test_done;
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    xf(0, 0, 0);
    xf(1, 0, 32'hffff_ffff);
    xf(0, 0, 32'h0000_002d);
    ck("outs", o, 7'h7e);
    xf(1, 0, 32'h0000_0040);
    xf(0, 0, 0);
    ck("outs", o, 0);
    i_udc_host.tok;
    repeat (2) @(posedge pclk);
    ck("outs", o, 7'h02);
    i_udc_host.se0(1);
    repeat (3) @(posedge pclk);
    xf(0, 0, 32'h0000_0060);
    xf(1, 0, 32'h0000_0002);
    xf(0, 4, 32'h0000_0002);
    fork
      xf(1, 0, 0);
      begin @(posedge pclk); i_udc_host.tok; end
    join
    i_udc_host.se0(0);
    repeat (3) @(posedge pclk);
    xf(0, 0, 32'h0000_0020);
    xf(1, 12'h008, 32'hffff_ffff);
    xf(0, 12'h008, 0);
    xf(0, 0, 32'h0000_0020);
    xf(1, 0, 32'h0000_002d);
    @(posedge pclk) presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    xf(0, 0, 0);
    xf(0, 4, 0);
    ck("outs", o, 0);
    test_done;
  end
endmodule // testbench
`default_nettype wire
